// File: design/dhp_pkg.sv
// Package for the dual-channel host bus port: widths, channel codes, carriers.
// Assumes a single 20 MHz clock domain and eight host-visible registers per channel.
package dhp_pkg;
   localparam int DHP_ADDR_W = 3;
   localparam int DHP_DATA_W = 8;
   localparam int DHP_NUM_REGS = 8;
   localparam int DHP_NUM_CHAN = 2;
   localparam int DHP_CHAN_A = 0;
   localparam int DHP_CHAN_B = 1;
   localparam logic DHP_PICK_A = 1'h1;
   localparam int DHP_BCAST_BIT = 0;
   localparam logic [7:0] DHP_REG_RST = 8'h00;
   localparam logic [2:0] DHP_SYNC_RST = 3'h7;
   localparam logic [5:0] DHP_STAT_RST = 6'h0F;

   typedef struct packed {
      logic [DHP_ADDR_W-1:0] addr;
      logic [DHP_DATA_W-1:0] data;
   } dhp_access_t;

   typedef struct packed {
      logic irq;
      logic tx_ready;
      logic rx_ready;
   } dhp_chan_stat_t;
endpackage

// File: design/dhp_port.sv
// Host bus port of a two-channel UART: strobes, chip select, channel pick, data bus.
// Assumes host pins are asynchronous to clk and each channel's core supplies status.
`timescale 1ns/1ns
`default_nettype none
module dhp_port
   import dhp_pkg::*;
#(
   parameter int NUM_REGS = DHP_NUM_REGS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic channel_pick,
   input wire logic [DHP_ADDR_W-1:0] reg_addr,
   input wire logic [DHP_DATA_W-1:0] data_in,
   output logic [DHP_DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic alternate_function_ctrl,
   input wire dhp_chan_stat_t stat_a,
   input wire dhp_chan_stat_t stat_b,
   output logic irq_chan_a,
   output logic irq_chan_b,
   output logic tx_ready_chan_a_n,
   output logic tx_ready_chan_b_n,
   output logic rx_ready_chan_a_n,
   output logic rx_ready_chan_b_n
);
   // ==========================================================
   // Pin synchronisers.
   // Strobes are asynchronous, so every host pin but alternate_function_ctrl passes two flops before use.
   logic [2:0] s1_q, s2_q, s3_q;
   logic [2:0] pin_raw;
   logic pick1_q, pick2_q;
   dhp_access_t acc1_q, acc2_q;
   assign pin_raw = {chip_select_n, read_strobe_n, write_strobe_n};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= DHP_SYNC_RST;
         s2_q <= DHP_SYNC_RST;
         s3_q <= DHP_SYNC_RST;
         pick1_q <= 1'h0;
         pick2_q <= 1'h0;
         acc1_q <= '0;
         acc2_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pick1_q <= channel_pick;
         pick2_q <= pick1_q;
         acc1_q <= '{addr: reg_addr, data: data_in};
         acc2_q <= acc1_q;
      end
   end

   logic cs_n, rd_n, wr_n, rd_fall, wr_rise;
   assign cs_n = s2_q[2];
   assign rd_n = s2_q[1];
   assign wr_n = s2_q[0];
   assign rd_fall = s3_q[1] && !rd_n;
   assign wr_rise = !s3_q[0] && wr_n;

   // ==========================================================
   // Register arrays and access logic.
   // The data lines are synchronised too; the host holds them over the strobe.
   // Drive and release lag the pins by three clocks; a host that turns the bus
   // around sooner than that would meet the port's drivers on the wires.
   logic [DHP_DATA_W-1:0] regs_q [DHP_NUM_CHAN][NUM_REGS];
   logic [DHP_DATA_W-1:0] data_out_q, data_out_d;
   logic data_oe_q, data_oe_d;
   logic sel_b;
   logic [DHP_NUM_CHAN-1:0] wr_en;
   assign sel_b = (pick2_q != DHP_PICK_A);

   always_comb begin
      wr_en = '0;
      if (wr_rise && !cs_n) begin
         if (alternate_function_ctrl) begin
            wr_en = '1;
         end else begin
            wr_en[DHP_CHAN_B] = sel_b;
            wr_en[DHP_CHAN_A] = !sel_b;
         end
      end
   end

   genvar gc;
   generate
      for (gc = 0; gc < DHP_NUM_CHAN; gc++) begin : g_chan
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               for (int r = 0; r < NUM_REGS; r++) begin
                  regs_q[gc][r] <= DHP_REG_RST;
               end
            end else if (wr_en[gc]) begin
               regs_q[gc][acc2_q.addr] <= acc2_q.data;
            end
         end
      end
   endgenerate

   always_comb begin
      data_out_d = data_out_q;
      data_oe_d = !cs_n && !rd_n && data_oe_q;
      if (rd_fall && !cs_n) begin
         data_out_d = regs_q[sel_b ? DHP_CHAN_B : DHP_CHAN_A][acc2_q.addr];
         data_oe_d = 1'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_out_q <= DHP_REG_RST;
         data_oe_q <= 1'h0;
      end else begin
         data_out_q <= data_out_d;
         data_oe_q <= data_oe_d;
      end
   end
   assign data_out = data_out_q;
   assign data_oe = data_oe_q;

   // ==========================================================
   // Channel status outputs, registered from the cores' status.
   logic [5:0] stat_q, stat_d;
   always_comb begin
      stat_d = {stat_a.irq, stat_b.irq,
                !stat_a.tx_ready, !stat_b.tx_ready,
                !stat_a.rx_ready, !stat_b.rx_ready};
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q <= DHP_STAT_RST;
      end else begin
         stat_q <= stat_d;
      end
   end
   assign irq_chan_a = stat_q[5];
   assign irq_chan_b = stat_q[4];
   assign tx_ready_chan_a_n = stat_q[3];
   assign tx_ready_chan_b_n = stat_q[2];
   assign rx_ready_chan_a_n = stat_q[1];
   assign rx_ready_chan_b_n = stat_q[0];

   // ==========================================================
   // Checks.
   sequence s_rd_start;
      !cs_n && rd_fall;
   endsequence
   property p_read_drive;
      @(posedge clk) disable iff (rst) s_rd_start |=> data_oe_q;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read not driven");
   property p_release;
      @(posedge clk) disable iff (rst) (cs_n || rd_n) |=> !data_oe_q;
   endproperty
   a_release: assert property (p_release) else $error("bus not released");
   property p_hold;
      @(posedge clk) disable iff (rst) (data_oe_q && !rd_fall) |=> $stable(data_out_q);
   endproperty
   a_hold: assert property (p_hold) else $error("read byte changed");
   property p_write;
      @(posedge clk) disable iff (rst) (wr_en[DHP_CHAN_A])
         |=> regs_q[DHP_CHAN_A][$past(acc2_q.addr)] == $past(acc2_q.data);
   endproperty
   a_write: assert property (p_write) else $error("write lost");
   property p_cs;
      @(posedge clk) disable iff (rst) cs_n |-> wr_en == '0;
   endproperty
   a_cs: assert property (p_cs) else $error("write without select");
   property p_pick;
      @(posedge clk) disable iff (rst)
         (wr_rise && !cs_n && !alternate_function_ctrl) |-> wr_en[DHP_CHAN_B] == !pick2_q;
   endproperty
   a_pick: assert property (p_pick) else $error("wrong channel");
   property p_bcast;
      @(posedge clk) disable iff (rst)
         (wr_rise && !cs_n && alternate_function_ctrl) |-> wr_en == '1;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast missed");
   property p_irq;
      @(posedge clk) disable iff (rst) stat_a.irq |=> irq_chan_a;
   endproperty
   a_irq: assert property (p_irq) else $error("irq a missing");
   property p_tx;
      @(posedge clk) disable iff (rst) stat_b.tx_ready |=> !tx_ready_chan_b_n;
   endproperty
   a_tx: assert property (p_tx) else $error("tx ready b wrong");
   property p_rx;
      @(posedge clk) disable iff (rst) !stat_a.rx_ready |=> rx_ready_chan_a_n;
   endproperty
   a_rx: assert property (p_rx) else $error("rx ready a wrong");
   property p_write_b;
      @(posedge clk) disable iff (rst) (wr_en[DHP_CHAN_B])
         |=> regs_q[DHP_CHAN_B][$past(acc2_q.addr)] == $past(acc2_q.data);
   endproperty
   a_write_b: assert property (p_write_b) else $error("write b lost");
   property p_irq_b;
      @(posedge clk) disable iff (rst) !stat_b.irq |=> !irq_chan_b;
   endproperty
   a_irq_b: assert property (p_irq_b) else $error("irq b stuck");
   property p_tx_a;
      @(posedge clk) disable iff (rst) !stat_a.tx_ready |=> tx_ready_chan_a_n;
   endproperty
   a_tx_a: assert property (p_tx_a) else $error("tx ready a wrong");
   property p_rx_b;
      @(posedge clk) disable iff (rst) stat_b.rx_ready |=> !rx_ready_chan_b_n;
   endproperty
   a_rx_b: assert property (p_rx_b) else $error("rx ready b wrong");
endmodule
`default_nettype wire

// File: tb/dhp_host.sv
// Host processor model: drives strobes, chip select, channel pick, address and write data.
// Assumes the bench resolves the data bus wire and feeds its level back on bus.
`timescale 1ns/1ns
`default_nettype none
module dhp_host (
   input wire logic clk,
   input wire logic [7:0] bus,
   output logic cs_n = 1'h1,
   output logic rd_n = 1'h1,
   output logic wr_n = 1'h1,
   output logic pick = 1'h0,
   output logic [2:0] addr = 3'h0,
   output logic [7:0] drv = 8'h00,
   output logic drv_en = 1'h0,
   output logic rd_done = 1'h0,
   output logic [7:0] rd_byte = 8'h00
);
   // ==========
   // Bus cycle.
   // Setup of three clocks and hold of four cover the device's two-flop synchronisers.
   task automatic cyc(input logic w, input logic c, input logic p, input logic [2:0] a,
      input logic [7:0] d);
      @(negedge clk);
      cs_n = c;
      pick = p;
      addr = a;
      drv = d;
      drv_en = w;
      repeat (3) @(negedge clk);
      wr_n = !w;
      rd_n = w;
      repeat (5) @(negedge clk);
      rd_byte = bus;
      rd_done = !w && !c;
      rd_n = 1'h1;
      wr_n = 1'h1;
      @(negedge clk);
      rd_done = 1'h0;
      repeat (3) @(negedge clk);
      cs_n = 1'h1;
      drv_en = 1'h0;
      repeat (3) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// File: tb/dual_uart_host_bus_port_bench.sv
// Self-checking bench of the host bus port with a host model and a register model.
// Assumes the package constants and the hand-over timing of the port.
`timescale 1ns/1ns
`default_nettype none
module dual_uart_host_bus_port_bench;
   import dhp_pkg::*;
   // ==========
   // Wiring.
   logic clk = 1'h0, rst = 1'h1, afc = 1'h0, cs_n, rd_n, wr_n, pick, drv_en, rd_done, oe;
   logic [2:0] addr;
   logic [7:0] drv, rd_byte, dout, bus_last = 8'h00, ref_a [8], ref_b [8];
   logic ia, ib, ta_n, tb_n, ra_n, rb_n;
   dhp_chan_stat_t sa = 3'h0, sb = 3'h0;
   int bad_count = 0, total_checks = 0, idle_cnt = 0, seed = 32'h6450;
   logic [7:0] exp_q [$];
   // With nobody driving, the wire flips every cycle so a stale byte never passes.
   wire logic [7:0] bus = oe ? dout : (drv_en ? drv : ~bus_last);
   always #25 clk = ~clk;
   always @(posedge clk) bus_last <= bus;
   dhp_host i_host (.clk(clk), .bus(bus), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .pick(pick),
      .addr(addr), .drv(drv), .drv_en(drv_en), .rd_done(rd_done), .rd_byte(rd_byte));
   dhp_port i_dut (.clk(clk), .rst(rst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .channel_pick(pick), .reg_addr(addr), .data_in(bus),
      .data_out(dout), .data_oe(oe), .alternate_function_ctrl(afc), .stat_a(sa), .stat_b(sb),
      .irq_chan_a(ia), .irq_chan_b(ib), .tx_ready_chan_a_n(ta_n), .tx_ready_chan_b_n(tb_n),
      .rx_ready_chan_a_n(ra_n), .rx_ready_chan_b_n(rb_n));
   // ==========
   // Checking.
   task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge rd_done) begin
      if (exp_q.size() > 0) cmp("read_byte", exp_q.pop_front(), rd_byte);
      else cmp("read_queue", 8'h01, 8'h00);
   end
   always @(negedge clk) begin
      idle_cnt <= (cs_n || rd_n) ? idle_cnt + 1 : 0;
      if (idle_cnt > 3) cmp("data_oe", 8'h00, {7'h00, oe});
   end
   // ==========
   // Stimulus.
   task automatic access(input logic w, input logic c, input logic p, input logic [2:0] a,
      input logic [7:0] d);
      if (w && !c && (afc || p)) ref_a[a] = d;
      if (w && !c && (afc || !p)) ref_b[a] = d;
      if (!w && !c) exp_q.push_back(p ? ref_a[a] : ref_b[a]);
      i_host.cyc(w, c, p, a, d);
   endtask
   task automatic read_all;
      for (int i = 0; i < 16; i++) access(1'h0, 1'h0, i[3], i[2:0], 8'h00);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      cmp("timeout", 8'h00, 8'h01);
      print_verdict;
   end
   initial begin
      for (int i = 0; i < 8; i++) begin
         ref_a[i] = DHP_REG_RST;
         ref_b[i] = DHP_REG_RST;
      end
      repeat (5) @(negedge clk);
      rst = 1'h0;
      repeat (3) @(negedge clk);
      read_all;
      for (int i = 0; i < 60; i++) begin
         afc = ($random(seed) & 7) == 0;
         access(1'($random(seed)), ($random(seed) & 7) == 0, 1'($random(seed)),
            3'($random(seed)), 8'($random(seed)));
      end
      afc = 1'h0;
      read_all;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk);
         sa = 3'($random(seed));
         sb = 3'($random(seed));
         @(negedge clk);
         cmp("stat_a", {5'h00, sa}, {5'h00, ia, !ta_n, !ra_n});
         cmp("stat_b", {5'h00, sb}, {5'h00, ib, !tb_n, !rb_n});
      end
      // A reset in mid-run must clear both register banks and park the status pins.
      @(negedge clk);
      rst = 1'h1;
      @(negedge clk);
      cmp("reset_stat", {2'h0, DHP_STAT_RST},
         {2'h0, ia, ib, ta_n, tb_n, ra_n, rb_n});
      cmp("reset_oe", 8'h00, {7'h00, oe});
      repeat (3) @(negedge clk);
      rst = 1'h0;
      for (int i = 0; i < 8; i++) begin
         ref_a[i] = DHP_REG_RST;
         ref_b[i] = DHP_REG_RST;
      end
      repeat (3) @(negedge clk);
      read_all;
      cmp("reads_left", 8'h00, 8'(exp_q.size()));
      print_verdict;
   end
endmodule
`default_nettype wire
